// ==== common/prefix_decoder_pkg.sv ====
package prefix_decoder_pkg;

  // Function codes in the high nibble of an instruction byte.
  localparam logic [3:0] FN_PREFIX     = 4'h2;
  localparam logic [3:0] FN_LOAD_CONST = 4'h4;
  localparam logic [3:0] FN_NEG_PREFIX = 4'h6;
  localparam logic [3:0] FN_OPERATE    = 4'hF;

  // Field positions inside an instruction byte.
  localparam int FN_MSB  = 7;
  localparam int FN_LSB  = 4;
  localparam int NIB_MSB = 3;
  localparam int NIB_LSB = 0;

  // Operation codes used by this block.
  localparam logic [31:0] OP_DEVICE_ID = 32'h0000017C;
  localparam logic [31:0] OP_FP_ENTRY  = 32'h000000AB;

  // Identity number loaded by the device-identity operation; value is arbitrary.
  localparam logic [31:0] DEVICE_ID_VALUE = 32'h000000A5;

  // Reset values.
  localparam logic [31:0] OPERAND_RESET = 32'h00000000;
  localparam logic [31:0] AREG_RESET    = 32'h00000000;
  localparam logic [7:0]  COUNT_RESET   = 8'h00;
  localparam logic [3:0]  FUNC_RESET    = 4'h0;
  localparam logic [4:0]  TOPBIT_RESET  = 5'h00;
  localparam logic [31:0] WORDS_RESET   = 32'h00000000;

  // Cost in processor cycles of one prefix byte.
  localparam logic [7:0] PREFIX_CYCLES = 8'h01;

  // Width of the cycle counts.
  localparam int CYC_W = 8;

  // Decoder sequencing states.
  typedef enum logic [1:0]
  {
    ST_IDLE  = 2'b01,
    ST_ISSUE = 2'b10
  } dec_state_t;

endpackage

// ==== logic/highest_bit_index.sv ====
`timescale 1ns/1ps

// Gives the index of the highest set bit of a word, zero when the word is zero.
module highest_bit_index
  import prefix_decoder_pkg::*;
(
  // Word to scan.
  input  wire logic [31:0] word_in,
  // Index of its highest set bit.
  output logic      [4:0]  index_out
);

  // Scan upward so that the last set bit seen wins.
  always_comb
  begin
    index_out = 5'h00;
    for (int i = 0; i < 32; i++)
    begin
      if (word_in[i])
      begin
        index_out = 5'(i);
      end
    end
  end

endmodule

// ==== logic/prefix_instruction_decoder.sv ====
`timescale 1ns/1ps

// Notes on behaviour
// - Operand below 16 is a single byte
// - Each prefix adds four operand bits
// - Negating prefix complements before accumulating
// - Short operation code in one operate byte
// - Long operation code uses prefix then operate
// - Device identity operation loads identity into A
// - Load constant selects floating-point entry operation
// - Floating-point dispatch overlaps integer issue
// - Each prefix byte costs one extra cycle
// - Cycles counted in processor clock periods
// - Data-dependent timing uses A's highest bit
// - Message words count partial end words
module prefix_instruction_decoder
  import prefix_decoder_pkg::*;
(
  // Clock and reset.
  input  wire logic              sys_clk_in,
  input  wire logic              rstn_in,
  // Instruction byte from fetch.
  input  wire logic              byte_valid_in,
  input  wire logic [7:0]        byte_in,
  output logic                   byte_ready_out,
  // Message-move byte address and length for word counting.
  input  wire logic [31:0]       move_addr_in,
  input  wire logic [31:0]       move_len_in,
  // Decoded instruction to the execution units.
  output logic                   issue_valid_out,
  output logic [3:0]             issue_func_out,
  output logic [31:0]            issue_operand_out,
  output logic                   issue_is_operate_out,
  output logic [CYC_W-1:0]       issue_prefix_cycles_out,
  // Evaluation stack top and timing helpers.
  output logic [31:0]            areg_out,
  output logic [4:0]             areg_top_bit_out,
  output logic [31:0]            move_words_out,
  // Floating-point dispatch.
  output logic                   fp_dispatch_out,
  output logic [31:0]            fp_selector_out
);

  // Every register is paired with its next value from the processes below.
  dec_state_t        state_r, state_nxt;         // Sequencer state.
  logic [31:0]       oreg_r, oreg_nxt;           // Operand accumulator.
  logic [CYC_W-1:0]  pcnt_r, pcnt_nxt;           // Prefix cycles of current instruction.
  logic [31:0]       areg_r, areg_nxt;           // Top of evaluation stack.
  logic              iv_r, iv_nxt;               // Issue valid.
  logic [3:0]        ifn_r, ifn_nxt;             // Issued function code.
  logic [31:0]       iop_r, iop_nxt;             // Issued operand.
  logic              iopr_r, iopr_nxt;           // Issued instruction is an operate.
  logic [CYC_W-1:0]  icyc_r, icyc_nxt;           // Issued prefix cycle cost.
  logic              fpd_r, fpd_nxt;             // Floating-point dispatch pulse.
  logic [31:0]       fps_r, fps_nxt;             // Floating-point selector.
  logic [4:0]        topbit_r, topbit_nxt;       // Highest bit index of A.
  logic [31:0]       mw_r, mw_nxt;               // Message word count.
  logic [4:0]        topbit_w;                   // Combinational highest bit of A.
  logic [3:0]        fn_w;                       // Function nibble of incoming byte.
  logic [3:0]        nib_w;                      // Operand nibble of incoming byte.
  logic [31:0]       full_w;                     // Complete operand of incoming byte.
  logic [33:0]       span_w;                     // Byte span end for word counting.

  // The index scan sits in its own module so timing helpers can reuse it.
  // Registering its result keeps a 32-bit priority chain off the output path.
  highest_bit_index u_topbit
  (
    .word_in   (areg_r),
    .index_out (topbit_w)
  );

  // Split the byte and form the operand it completes.
  // The accumulator's low nibble is always zero here, so OR simply inserts the nibble.
  always_comb
  begin
    fn_w   = byte_in[FN_MSB:FN_LSB];
    nib_w  = byte_in[NIB_MSB:NIB_LSB];
    full_w = oreg_r | {28'h0000000, nib_w};
  end

  // Decode each accepted byte; prefixes accumulate, others issue.
  // Defaults hold every register but the two strobes, so an idle cycle with no byte offered changes nothing else.
  // The issue and dispatch strobes default low, which makes them one-cycle pulses.
  always_comb
  begin
    state_nxt = state_r;
    oreg_nxt  = oreg_r;
    pcnt_nxt  = pcnt_r;
    areg_nxt  = areg_r;
    iv_nxt    = 1'b0;
    ifn_nxt   = ifn_r;
    iop_nxt   = iop_r;
    iopr_nxt  = iopr_r;
    icyc_nxt  = icyc_r;
    fpd_nxt   = 1'b0;
    fps_nxt   = fps_r;
    unique case (state_r)
      ST_IDLE:
      begin
        // Bytes are taken only in idle, which is the state that drives ready high.
        if (byte_valid_in)
        begin
          if (fn_w == FN_PREFIX)
          begin
            // Upper bits of a long operand or operation code.
            oreg_nxt = {full_w[27:0], 4'h0};
            pcnt_nxt = pcnt_r + PREFIX_CYCLES;
          end
          else if (fn_w == FN_NEG_PREFIX)
          begin
            // Complement before shifting builds a negative operand.
            oreg_nxt = {~full_w[27:0], 4'h0};
            pcnt_nxt = pcnt_r + PREFIX_CYCLES;
          end
          else
          begin
            // The completed instruction issues and the accumulator clears.
            iv_nxt    = 1'b1;
            ifn_nxt   = fn_w;
            iop_nxt   = full_w;
            iopr_nxt  = (fn_w == FN_OPERATE);
            icyc_nxt  = pcnt_r;
            oreg_nxt  = OPERAND_RESET;
            pcnt_nxt  = COUNT_RESET;
            state_nxt = ST_ISSUE;
            // Only a constant load and the identity operation write A.
            if (fn_w == FN_LOAD_CONST)
            begin
              areg_nxt = full_w;
            end
            else if (fn_w == FN_OPERATE && full_w == OP_DEVICE_ID)
            begin
              areg_nxt = DEVICE_ID_VALUE;
            end
            else if (fn_w == FN_OPERATE && full_w == OP_FP_ENTRY)
            begin
              // The selector leaves at once; integer issue does not wait on it.
              fpd_nxt = 1'b1;
              fps_nxt = areg_r;
            end
          end
        end
      end
      ST_ISSUE:
      begin
        // One spare cycle lets the execution units take the issued word.
        state_nxt = ST_IDLE;
      end
      default:
      begin
        // An illegal code falls back to idle rather than stalling fetch for good.
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Timing helpers: highest bit of A and message word count.
  // Both are registered, so each trails its source by one clock.
  // The 34-bit sum cannot wrap, even for the longest length.
  always_comb
  begin
    topbit_nxt = topbit_w;
    span_w     = {2'b00, move_addr_in[1:0]} + {2'b00, move_len_in} + 34'h000000003;
    // Alignment offset plus length, rounded up, counts both partial end words.
    mw_nxt     = (move_len_in == 32'h00000000) ? 32'h00000000 : span_w[33:2];
  end

  // Register all decoder state.
  // Reset puts the sequencer in idle, so ready is high while reset is held.
  // Every reset value is a constant, so release carries no stale data.
  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state_r  <= ST_IDLE;
      oreg_r   <= OPERAND_RESET;
      pcnt_r   <= COUNT_RESET;
      areg_r   <= AREG_RESET;
      iv_r     <= 1'b0;
      ifn_r    <= FUNC_RESET;
      iop_r    <= OPERAND_RESET;
      iopr_r   <= 1'b0;
      icyc_r   <= COUNT_RESET;
      fpd_r    <= 1'b0;
      fps_r    <= AREG_RESET;
      topbit_r <= TOPBIT_RESET;
      mw_r     <= WORDS_RESET;
    end
    else
    begin
      state_r  <= state_nxt;
      oreg_r   <= oreg_nxt;
      pcnt_r   <= pcnt_nxt;
      areg_r   <= areg_nxt;
      iv_r     <= iv_nxt;
      ifn_r    <= ifn_nxt;
      iop_r    <= iop_nxt;
      iopr_r   <= iopr_nxt;
      icyc_r   <= icyc_nxt;
      fpd_r    <= fpd_nxt;
      fps_r    <= fps_nxt;
      topbit_r <= topbit_nxt;
      mw_r     <= mw_nxt;
    end
  end

  // The outputs below are plain copies of registers; no logic sits after them.
  // Ready is a decoded state bit, so it comes straight from a flip-flop.
  assign byte_ready_out          = state_r[0];
  assign issue_valid_out         = iv_r;
  assign issue_func_out          = ifn_r;
  assign issue_operand_out       = iop_r;
  assign issue_is_operate_out    = iopr_r;
  assign issue_prefix_cycles_out = icyc_r;
  assign areg_out                = areg_r;
  assign areg_top_bit_out        = topbit_r;
  assign move_words_out          = mw_r;
  assign fp_dispatch_out         = fpd_r;
  assign fp_selector_out         = fps_r;

endmodule

// ==== sim/decoder_monitor.sv ====
`timescale 1ns/1ps

// Port checker; each relation is tied to a byte taken, an issue pulse, a dispatch pulse or A holding still.
module decoder_monitor
  import prefix_decoder_pkg::*;
(
  // Clock, reset and fetch side.
  input  wire logic        sys_clk_in,
  input  wire logic        rstn_in,
  input  wire logic        byte_valid_in,
  input  wire logic [7:0]  byte_in,
  input  wire logic        byte_ready_out,
  // Issue side.
  input  wire logic        issue_valid_out,
  input  wire logic [3:0]  issue_func_out,
  input  wire logic [31:0] issue_operand_out,
  input  wire logic        issue_is_operate_out,
  input  wire logic [31:0] areg_out,
  input  wire logic [4:0]  areg_top_bit_out,
  input  wire logic        fp_dispatch_out
);
  logic tk; // A byte is taken at this edge.
  logic pf; // The offered byte is one of the two prefixes.
  assign tk = byte_valid_in && byte_ready_out;
  assign pf = (byte_in[7:4] == FN_PREFIX) || (byte_in[7:4] == FN_NEG_PREFIX);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  a_prefix_silent: assert property (tk && pf |=> !issue_valid_out)
    else $error("prefix byte caused an issue");
  a_issue_func: assert property (tk && !pf |=> issue_valid_out &&
    issue_func_out == $past(byte_in[7:4])) else $error("issue function wrong");
  a_nib_low: assert property (tk && !pf |=>
    issue_operand_out[3:0] == $past(byte_in[3:0])) else $error("operand nibble wrong");
  a_issue_bubble: assert property (issue_valid_out |->
    !byte_ready_out ##1 byte_ready_out) else $error("bubble after issue wrong");
  a_operate_flag: assert property (issue_valid_out |->
    issue_is_operate_out == (issue_func_out == FN_OPERATE)) else $error("operate flag wrong");
  a_const_load: assert property (issue_valid_out && issue_func_out == FN_LOAD_CONST |->
    areg_out == issue_operand_out) else $error("constant not loaded");
  a_dev_id: assert property (issue_valid_out && issue_is_operate_out &&
    issue_operand_out == OP_DEVICE_ID |-> areg_out == DEVICE_ID_VALUE) else $error("id wrong");
  a_fp_overlap: assert property (fp_dispatch_out |-> issue_valid_out &&
    issue_operand_out == OP_FP_ENTRY) else $error("fp dispatch without entry issue");
  // The index trails A by one clock, so it is only judged once A has held still.
  a_top_bit: assert property ($stable(areg_out) |->
    (areg_out >> areg_top_bit_out) == 32'h00000001 ||
    (areg_out == 32'h00000000 && areg_top_bit_out == 5'h00)) else $error("top bit wrong");
  // Main scenarios: dispatch, negative chain, identity load and a two-prefix chain.
  c_fp: cover property (fp_dispatch_out);
  c_neg: cover property (tk && byte_in[7:4] == FN_NEG_PREFIX);
  c_id: cover property (issue_valid_out && issue_operand_out == OP_DEVICE_ID);
  c_chain: cover property (tk && pf ##1 tk && pf);
endmodule

// ==== sim/fetch_model.sv ====
`timescale 1ns/1ps

// Fetch stage: offers queued bytes and holds each until the decoder takes it.
module fetch_model
(
  // Clock and handshake from the decoder.
  input  wire logic       clk_in,
  input  wire logic       ready_in,
  // Byte offered to the decoder.
  output logic            valid_out,
  output logic [7:0]      byte_out
);
  logic [7:0] q[$]; // Bytes waiting, filled by the bench.
  // One process drives the bus, so each output has a single driver.
  // An idle bus toggles so that a stale byte is never mistaken for a new one.
  initial
  begin
    valid_out = 1'b0;
    byte_out  = 8'h00;
    forever
    begin
      @(posedge clk_in);
      // The head byte leaves only at an edge where the decoder took it.
      if (valid_out && ready_in)
      begin
        void'(q.pop_front());
      end
      #1;
      valid_out = q.size() != 0;
      byte_out  = valid_out ? q[0] : ~byte_out;
    end
  end
endmodule

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps

module tb_top
  import prefix_decoder_pkg::*;
;
  logic sys_clk_in, rstn_in, byte_valid_in, byte_ready_out, issue_valid_out, fp_dispatch_out;
  logic issue_is_operate_out;
  logic [7:0] byte_in, issue_prefix_cycles_out;
  logic [3:0] issue_func_out, f;
  logic [4:0] areg_top_bit_out;
  logic [31:0] move_addr_in, move_len_in, issue_operand_out, areg_out, move_words_out;
  logic [31:0] fp_selector_out, seed, v, exp_a;
  int n_fail, checks_done, nb, cyc;
  logic fp_seen;
  logic [31:0] corner[8] = '{32'h0, 32'hF, 32'h10, 32'hFFFFFFFF, 32'hFFFFFFE1, 32'h987,
                             32'h7FFFFFFF, 32'h80000000};
  prefix_instruction_decoder i_dut
  (
    .sys_clk_in              (sys_clk_in),
    .rstn_in                 (rstn_in),
    .byte_valid_in           (byte_valid_in),
    .byte_in                 (byte_in),
    .byte_ready_out          (byte_ready_out),
    .move_addr_in            (move_addr_in),
    .move_len_in             (move_len_in),
    .issue_valid_out         (issue_valid_out),
    .issue_func_out          (issue_func_out),
    .issue_operand_out       (issue_operand_out),
    .issue_is_operate_out    (issue_is_operate_out),
    .issue_prefix_cycles_out (issue_prefix_cycles_out),
    .areg_out                (areg_out),
    .areg_top_bit_out        (areg_top_bit_out),
    .move_words_out          (move_words_out),
    .fp_dispatch_out         (fp_dispatch_out),
    .fp_selector_out         (fp_selector_out)
  );
  fetch_model i_fetch (.clk_in(sys_clk_in), .ready_in(byte_ready_out),
    .valid_out(byte_valid_in), .byte_out(byte_in));
  always #12.5 sys_clk_in = ~sys_clk_in;
  // A hang ends the run as a failure.
  always @(posedge sys_clk_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      results();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task results();
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [4:0] hb(input logic [31:0] x);
    hb = 5'h0;
    for (int i = 0; i < 32; i++)
      if (x[i])
        hb = i[4:0];
  endfunction
  // Builds the shortest prefix chain for an operand, negative chains end with the inverter just before the final byte.
  task automatic enc(input logic [3:0] fn, input logic [31:0] x);
    if (x[31])
      enc(FN_NEG_PREFIX, ~x >> 4);
    else if (x > 32'hF)
      enc(FN_PREFIX, x >> 4);
    nb++;
    i_fetch.q.push_back({fn, x[3:0]});
  endtask
  // Words a message touches: last word index less first word index, plus one.
  function automatic logic [31:0] words(input logic [31:0] a, input logic [31:0] n);
    if (n == 32'h00000000)
      return 32'h00000000;
    return ((({30'h00000000, a[1:0]}) + n - 32'h00000001) >> 2) + 32'h00000001;
  endfunction
  // Sends one instruction and checks the issue, A and the move word count.
  task automatic go(input logic [3:0] fn, input logic [31:0] x);
    logic [31:0] ew;
    logic        fp_exp;
    move_addr_in = seed;
    move_len_in = {24'h000000, seed[15:8]};
    ew = words(move_addr_in, move_len_in);
    // Only a constant load and the identity operation change A.
    fp_exp = (fn == FN_OPERATE) && (x == OP_FP_ENTRY);
    if (fn == FN_LOAD_CONST)
      exp_a = x;
    else if (fn == FN_OPERATE && x == OP_DEVICE_ID)
      exp_a = DEVICE_ID_VALUE;
    nb = 0;
    fp_seen = 1'b0;
    enc(fn, x);
    for (int i = 0; i < 60 && issue_valid_out !== 1'b1; i++)
    begin
      @(posedge sys_clk_in);
      #1;
    end
    fp_seen = fp_dispatch_out;
    chk(issue_func_out, fn);
    chk(issue_operand_out, x);
    chk(issue_prefix_cycles_out, nb - 1);
    chk(issue_is_operate_out, fn == FN_OPERATE);
    chk(areg_out, exp_a);
    chk(fp_seen, fp_exp);
    if (fp_exp)
      chk(fp_selector_out, exp_a);
    @(posedge sys_clk_in);
    #1;
    chk(areg_top_bit_out, hb(exp_a));
    chk(move_words_out, ew);
  endtask
  initial
  begin
    sys_clk_in = 1'b0;
    rstn_in = 1'b0;
    move_addr_in = 32'h0;
    move_len_in = 32'h0;
    seed = 32'h3A1A936C;
    exp_a = AREG_RESET;
    repeat (20) @(posedge sys_clk_in);
    #1 rstn_in = 1'b1;
    foreach (corner[k])
      go(FN_LOAD_CONST, corner[k]);
    repeat (40)
    begin
      seed = xs(seed);
      f = seed[31:28];
      if (f == FN_PREFIX || f == FN_NEG_PREFIX)
        f = FN_LOAD_CONST;
      v = $signed(seed) >>> seed[4:0];
      go(f, v);
    end
    go(FN_OPERATE, 32'h5);
    chk(issue_is_operate_out, 1'b1);
    go(FN_OPERATE, OP_DEVICE_ID);
    chk(areg_out, DEVICE_ID_VALUE);
    go(FN_LOAD_CONST, 32'h1C);
    go(FN_OPERATE, OP_FP_ENTRY);
    chk(fp_seen, 1'b1);
    chk(fp_selector_out, 32'h1C);
    results();
  end
endmodule

bind prefix_instruction_decoder decoder_monitor i_mon (.sys_clk_in(sys_clk_in),
  .rstn_in(rstn_in), .byte_valid_in(byte_valid_in), .byte_in(byte_in),
  .byte_ready_out(byte_ready_out), .issue_valid_out(issue_valid_out),
  .issue_func_out(issue_func_out), .issue_operand_out(issue_operand_out),
  .issue_is_operate_out(issue_is_operate_out), .areg_out(areg_out),
  .areg_top_bit_out(areg_top_bit_out), .fp_dispatch_out(fp_dispatch_out));
